// ---- design/bfr_pkg.sv ----
// Constants, register map and carrier types of the buck fault sequencer.
// Assumes a 40 MHz system clock; all counts derive from it.
package bfr_pkg;
  localparam int CLK_NS     = 25;
  localparam int RAMP_NS    = 4_000_000;
  localparam int TOUT_NS    = 4_800_000;
  localparam int SAMPLE_NS  = 4_000_000;
  localparam int BLANK_NS   = 200;
  localparam int RAMP_CYC   = RAMP_NS / CLK_NS;
  localparam int TOUT_CYC   = TOUT_NS / CLK_NS;
  localparam int SAMPLE_CYC = SAMPLE_NS / CLK_NS;
  localparam int BLANK_CYC  = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam int SP_STEP    = SAMPLE_CYC / 640;
  localparam int REF_STEPS  = 64;
  localparam int REF_W      = 6;
  localparam int SP_W       = 10;
  localparam int SP_MAX_MV  = 550;
  localparam int TMR_W      = 24;
  localparam int BLK_W      = 4;
  localparam int ADDR_W     = 8;
  localparam int IRQ_W      = 4;
  ////////////////////////////////////////////////////////////////////////////
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_SETPT    = 8'h10;
  localparam logic [1:0]        RESP_OK       = 2'h0;
  localparam logic [1:0]        RESP_SLVERR   = 2'h2;
  localparam int                CTRL_EN       = 0;
  localparam logic              CTRL_EN_RST   = 1'h1;
  localparam int                STS_ST_LSB    = 0;
  localparam int                STS_OC_LOCK   = 4;
  localparam int                STS_UV_LATCH  = 5;
  localparam int                STS_POWER_GOOD_FLAG     = 6;
  localparam int                STS_DUMMY_N   = 7;
  localparam int                IRQ_OC        = 0;
  localparam int                IRQ_UV        = 1;
  localparam int                IRQ_SS_OK     = 2;
  localparam int                IRQ_PG_LOSS   = 3;
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ST_OFF, ST_SAMPLE, ST_SOFT, ST_RUN, ST_DUMMY, ST_UV_LATCH
  } bfr_state_t;
  typedef struct packed {
    logic enable;
    logic oc_trip;
    logic uv_trip;
    logic pg_bad;
    logic sp_cmp;
  } bfr_pins_t;
endpackage : bfr_pkg

// ---- design/bfr_sequencer.sv ----
// Overcurrent hiccup and undervoltage latch sequencer of a buck controller.
// Assumes comparator and enable pins are asynchronous; the PWM request is
// on I_CLK.
// Summary of operation
// - First low-side overcurrent trip drops both gates
// - Retry: two dummy time-outs, then soft-start
// - Trip during retry ramp restarts dummy pair
// - Clean soft-start leaves retry, resumes regulation
// - Retry period spans 9.6ms to 14.4ms
// - Shorted start-up handled as retry, guard active
// - Overcurrent guard cannot be disabled
// - Set point clamps between 0 and 550mV
// - Low-side gate undriven while sampling set point
// - Sense below 75 percent latches gates low
// - Undervoltage latch cleared only by reset
// - Undervoltage guard armed after soft-start only
// - Variant without guard never undervoltage latches
// - Earlier overcurrent trip blocks undervoltage latch
// - Power-good check stays active in every variant
// - Reference ramps digitally in steps over 4ms
// - Monitor from 200ns after low-side rise
// - Re-enable repeats set-point sample before soft-start
`timescale 1ns/100ps
module bfr_sequencer
  import bfr_pkg::*;
#(
  parameter int P_HAS_UV     = 1,
  parameter int P_TOUT_CYC   = bfr_pkg::TOUT_CYC,
  parameter int P_RAMP_CYC   = bfr_pkg::RAMP_CYC,
  parameter int P_SAMPLE_CYC = bfr_pkg::SAMPLE_CYC,
  parameter int P_SP_STEP    = bfr_pkg::SP_STEP
)(
  input  wire logic                      I_CLK,
  input  wire logic                      I_NRST,
  input  wire logic                      I_CE,
  input  wire bfr_pkg::bfr_pins_t        I_PINS,
  input  wire logic                      I_PWM_HS,
  output logic                           O_HS_GATE,
  output logic                           O_LS_GATE,
  output logic                           O_LS_GATE_OE,
  output logic [bfr_pkg::REF_W-1:0]      O_REF_CODE,
  output logic [bfr_pkg::SP_W-1:0]       O_SETPT_MV,
  output logic                           O_POWER_GOOD_FLAG,
  output logic                           O_IRQ,
  input  wire logic [bfr_pkg::ADDR_W-1:0] I_AXI_AWADDR,
  input  wire logic                      I_AXI_AWVALID,
  output logic                           O_AXI_AWREADY,
  input  wire logic [31:0]               I_AXI_WDATA,
  input  wire logic [3:0]                I_AXI_WSTRB,
  input  wire logic                      I_AXI_WVALID,
  output logic                           O_AXI_WREADY,
  output logic [1:0]                     O_AXI_BRESP,
  output logic                           O_AXI_BVALID,
  input  wire logic                      I_AXI_BREADY,
  input  wire logic [bfr_pkg::ADDR_W-1:0] I_AXI_ARADDR,
  input  wire logic                      I_AXI_ARVALID,
  output logic                           O_AXI_ARREADY,
  output logic [31:0]                    O_AXI_RDATA,
  output logic [1:0]                     O_AXI_RRESP,
  output logic                           O_AXI_RVALID,
  input  wire logic                      I_AXI_RREADY
);
  import bfr_pkg::*;

  localparam int STEP_CYC = P_RAMP_CYC / REF_STEPS;
  localparam logic [TMR_W-1:0] TOUT_END   = TMR_W'(P_TOUT_CYC - 1);
  localparam logic [TMR_W-1:0] SAMPLE_END = TMR_W'(P_SAMPLE_CYC - 1);
  localparam logic [TMR_W-1:0] STEP_END   = TMR_W'(STEP_CYC - 1);
  localparam logic [TMR_W-1:0] SP_DIV     = TMR_W'(P_SP_STEP);
  localparam logic [BLK_W-1:0] BLANK_END  = BLK_W'(BLANK_CYC);
  localparam logic [REF_W-1:0] REF_MAX    = REF_W'(REF_STEPS - 1);
  localparam logic [SP_W-1:0]  SP_MAX     = SP_W'(SP_MAX_MV);
  localparam int NPINS = $bits(bfr_pins_t);

  if (P_RAMP_CYC < REF_STEPS || P_TOUT_CYC < P_RAMP_CYC ||
      P_TOUT_CYC >= 2**TMR_W || P_SAMPLE_CYC < 1 || P_SP_STEP < 1 ||
      P_SAMPLE_CYC >= 2**TMR_W || BLANK_CYC >= 2**BLK_W)
  begin : g_bad_cfg
    $error("bfr_sequencer: unsupported timing parameters");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [NPINS-1:0] pin_vec;
  bfr_pins_t        pins_s;
  for (genvar g = 0; g < NPINS; g++)
  begin : g_sync
    logic meta_reg;
    logic sync_reg;
    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
      if (!I_NRST)
      begin
        meta_reg <= 1'b0;
        sync_reg <= 1'b0;
      end
      else if (I_CE)
      begin
        meta_reg <= I_PINS[g];
        sync_reg <= meta_reg;
      end
    end
    assign pin_vec[g] = sync_reg;
  end
  assign pins_s = bfr_pins_t'(pin_vec);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  bfr_state_t       state_reg;
  bfr_state_t       state_next;
  logic [TMR_W-1:0] tmr_reg;
  logic             dummy_n_reg;
  logic             oc_lock_reg;
  logic             ctrl_en_reg;
  logic             hs_reg;
  logic             ls_reg;
  logic             ls_oe_reg;
  logic [BLK_W-1:0] blank_reg;
  logic             en_act;
  logic             oc_hit;
  logic             uv_hit;
  logic             tout_done;
  logic             ss_ok;

  assign en_act    = pins_s.enable & ctrl_en_reg;
  assign tout_done = (tmr_reg == TOUT_END);
  // Guard has no off switch; it acts only while the low side conducts, after blanking
  assign oc_hit    = ls_reg && (blank_reg == BLANK_END) &&
                     pins_s.oc_trip;
  assign uv_hit    = (P_HAS_UV != 0) && (state_reg == ST_RUN) &&
                     pins_s.uv_trip && !oc_hit &&
                     !oc_lock_reg;
  assign ss_ok     = (state_reg == ST_SOFT) && tout_done && !oc_hit &&
                     en_act;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_OFF:
        if (en_act)
          state_next = ST_SAMPLE;
      ST_SAMPLE:
        if (tmr_reg == SAMPLE_END)
          state_next = ST_SOFT;
      ST_SOFT:
        if (oc_hit)
          state_next = ST_DUMMY;
        else if (tout_done)
          state_next = ST_RUN;
      ST_RUN:
        if (oc_hit)
          state_next = ST_DUMMY;
        else if (uv_hit)
          state_next = ST_UV_LATCH;
      ST_DUMMY:
        if (tout_done && dummy_n_reg)
          state_next = ST_SOFT;
      ST_UV_LATCH:
        state_next = ST_UV_LATCH;
    endcase
    if (!en_act && state_reg != ST_UV_LATCH)
      state_next = ST_OFF;
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      state_reg <= ST_OFF;
    else if (I_CE)
      state_reg <= state_next;
  end

  // Shared timer for sampling, soft-start and dummy time-outs
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      tmr_reg <= '0;
    else if (I_CE)
    begin
      if (state_next != state_reg || (state_reg == ST_DUMMY && tout_done))
        tmr_reg <= '0;
      else
        tmr_reg <= tmr_reg + TMR_W'(1);
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      dummy_n_reg <= 1'b0;
    else if (I_CE)
    begin
      if (state_reg != ST_DUMMY)
        dummy_n_reg <= 1'b0;
      else if (tout_done)
        dummy_n_reg <= ~dummy_n_reg;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      oc_lock_reg <= 1'b0;
    else if (I_CE)
    begin
      if (oc_hit)
        oc_lock_reg <= 1'b1;
      else if (ss_ok || state_reg == ST_OFF)
        oc_lock_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate drive and blanking
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      hs_reg    <= 1'b0;
      ls_reg    <= 1'b0;
      ls_oe_reg <= 1'b1;
    end
    else if (I_CE)
    begin
      ls_oe_reg <= (state_next != ST_SAMPLE);
      if ((state_next == ST_SOFT || state_next == ST_RUN) && !oc_hit)
      begin
        hs_reg <= I_PWM_HS;
        ls_reg <= ~I_PWM_HS;
      end
      else
      begin
        hs_reg <= 1'b0;
        ls_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      blank_reg <= '0;
    else if (I_CE)
    begin
      if (!ls_reg)
        blank_reg <= '0;
      else if (blank_reg != BLANK_END)
        blank_reg <= blank_reg + BLK_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference ramp and set-point sampling
  logic [REF_W-1:0] ref_reg;
  logic [TMR_W-1:0] step_reg;
  logic [SP_W-1:0]  sp_reg;
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      ref_reg  <= '0;
      step_reg <= '0;
    end
    else if (I_CE)
    begin
      if (state_reg == ST_RUN)
        ref_reg <= REF_MAX;
      else if (state_reg != ST_SOFT)
      begin
        ref_reg  <= '0;
        step_reg <= '0;
      end
      else if (step_reg == STEP_END)
      begin
        step_reg <= '0;
        if (ref_reg != REF_MAX)
          ref_reg <= ref_reg + REF_W'(1);
      end
      else
        step_reg <= step_reg + TMR_W'(1);
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      sp_reg <= '0;
    else if (I_CE)
    begin
      if (state_reg == ST_OFF)
        sp_reg <= '0;
      else if (state_reg == ST_SAMPLE && !pins_s.sp_cmp &&
               (tmr_reg % SP_DIV) == '0 &&
               sp_reg != SP_MAX)
        sp_reg <= sp_reg + SP_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power good and interrupts
  logic             pg_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_clr;
  logic             irq_reg;
  logic             rd_take;

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      pg_reg <= 1'b0;
    else if (I_CE)
      pg_reg <= (state_reg == ST_RUN) && !pins_s.pg_bad &&
                !oc_hit;
  end

  always_comb
  begin
    irq_ev              = '0;
    irq_ev[IRQ_OC]      = oc_hit;
    irq_ev[IRQ_UV]      = uv_hit;
    irq_ev[IRQ_SS_OK]   = ss_ok;
    irq_ev[IRQ_PG_LOSS] = pg_reg && !((state_reg == ST_RUN) &&
                          !pins_s.pg_bad && !oc_hit);
    irq_clr = (rd_take && I_AXI_ARADDR == ADDR_IRQ_STAT) ?
              irq_stat_reg : '0;
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      irq_stat_reg <= '0;
      irq_reg      <= 1'b0;
    end
    else if (I_CE)
    begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
      irq_reg      <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic              aw_reg;
  logic              w_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0]       wdata_reg;
  logic              wstrb0_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;
  logic              do_write;
  logic [31:0]       rd_mux;
  logic              rd_hit;

  assign O_AXI_AWREADY = I_CE && !aw_reg && !bvalid_reg;
  assign O_AXI_WREADY  = I_CE && !w_reg && !bvalid_reg;
  assign O_AXI_ARREADY = I_CE && !rvalid_reg;
  assign rd_take       = I_AXI_ARVALID && O_AXI_ARREADY;
  assign do_write      = aw_reg && w_reg && !bvalid_reg;

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      aw_reg     <= 1'b0;
      w_reg      <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg  <= '0;
      wstrb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OK;
    end
    else if (I_CE)
    begin
      if (I_AXI_AWVALID && O_AXI_AWREADY)
      begin
        aw_reg     <= 1'b1;
        awaddr_reg <= I_AXI_AWADDR;
      end
      if (I_AXI_WVALID && O_AXI_WREADY)
      begin
        w_reg      <= 1'b1;
        wdata_reg  <= I_AXI_WDATA;
        wstrb0_reg <= I_AXI_WSTRB[0];
      end
      if (do_write)
      begin
        aw_reg     <= 1'b0;
        w_reg      <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg  <= (awaddr_reg == ADDR_CTRL ||
                       awaddr_reg == ADDR_IRQ_MASK) ? RESP_OK : RESP_SLVERR;
      end
      else if (bvalid_reg && I_AXI_BREADY)
        bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      ctrl_en_reg  <= CTRL_EN_RST;
      irq_mask_reg <= '0;
    end
    else if (I_CE && do_write && wstrb0_reg)
    begin
      if (awaddr_reg == ADDR_CTRL)
        ctrl_en_reg <= wdata_reg[CTRL_EN];
      if (awaddr_reg == ADDR_IRQ_MASK)
        irq_mask_reg <= wdata_reg[IRQ_W-1:0];
    end
  end

  always_comb
  begin
    rd_mux = '0;
    rd_hit = 1'b1;
    unique case (I_AXI_ARADDR)
      ADDR_CTRL:
        rd_mux[CTRL_EN] = ctrl_en_reg;
      ADDR_STATUS:
      begin
        rd_mux[STS_ST_LSB +: 3] = state_reg;
        rd_mux[STS_OC_LOCK]     = oc_lock_reg;
        rd_mux[STS_UV_LATCH]    = (state_reg == ST_UV_LATCH);
        rd_mux[STS_POWER_GOOD_FLAG]       = pg_reg;
        rd_mux[STS_DUMMY_N]     = dummy_n_reg;
      end
      ADDR_IRQ_STAT:
        rd_mux[IRQ_W-1:0] = irq_stat_reg;
      ADDR_IRQ_MASK:
        rd_mux[IRQ_W-1:0] = irq_mask_reg;
      ADDR_SETPT:
        rd_mux[SP_W-1:0] = sp_reg;
      default:
        rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OK;
    end
    else if (I_CE)
    begin
      if (rd_take)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_mux;
        rresp_reg  <= rd_hit ? RESP_OK : RESP_SLVERR;
      end
      else if (rvalid_reg && I_AXI_RREADY)
        rvalid_reg <= 1'b0;
    end
  end

  assign O_HS_GATE    = hs_reg;
  assign O_LS_GATE    = ls_reg;
  assign O_LS_GATE_OE = ls_oe_reg;
  assign O_REF_CODE   = ref_reg;
  assign O_SETPT_MV   = sp_reg;
  assign O_POWER_GOOD_FLAG      = pg_reg;
  assign O_IRQ        = irq_reg;
  assign O_AXI_BVALID = bvalid_reg;
  assign O_AXI_BRESP  = bresp_reg;
  assign O_AXI_RVALID = rvalid_reg;
  assign O_AXI_RDATA  = rdata_reg;
  assign O_AXI_RRESP  = rresp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST || !I_CE);

  sequence s_gates_off;
    !hs_reg && !ls_reg;
  endsequence
  sequence s_latched;
    (state_reg == ST_UV_LATCH) && !hs_reg && !ls_reg;
  endsequence

  oc_shutoff_a: assert property (oc_hit |=> s_gates_off and
    (state_reg == ST_DUMMY))
    else $error("gates not off after overcurrent");
  dummy_pair_a: assert property (((state_reg == ST_SOFT) &&
    ($past(state_reg) == ST_DUMMY)) |-> $past(dummy_n_reg))
    else $error("soft-start began before second dummy");
  retry_restart_a: assert property (((state_reg == ST_SOFT) &&
    oc_hit) |=> (state_reg == ST_DUMMY) && !dummy_n_reg && tmr_reg == '0)
    else $error("trip in ramp did not restart dummy pair");
  good_ss_a: assert property (ss_ok |=> (state_reg == ST_RUN)
    ##1 (ref_reg == REF_MAX))
    else $error("clean soft-start did not resume regulation");
  dummy_len_a: assert property ((state_reg == ST_DUMMY) |->
    tmr_reg <= TOUT_END)
    else $error("dummy time-out overran");
  sample_float_a: assert property (((state_reg == ST_SAMPLE) &&
    ($past(state_reg) == ST_SAMPLE)) |-> !ls_oe_reg && !ls_reg)
    else $error("low-side gate driven while sampling");
  uv_latch_a: assert property (uv_hit |=> s_latched [*4])
    else $error("undervoltage latch not held");
  uv_arm_a: assert property (((state_reg == ST_UV_LATCH) &&
    ($past(state_reg) != ST_UV_LATCH)) |->
    ($past(state_reg) == ST_RUN) && !$past(oc_lock_reg))
    else $error("undervoltage latched outside regulation");
  no_uv_a: assert property ((P_HAS_UV == 0) |->
    (state_reg != ST_UV_LATCH))
    else $error("latch in variant without guard");
  sp_clamp_a: assert property (sp_reg <= SP_MAX)
    else $error("set point above clamp");
  oc_blank_a: assert property (oc_hit |-> ls_reg &&
    $past(ls_reg, 8))
    else $error("overcurrent seen inside blanking");
  reinit_a: assert property (((state_reg == ST_SOFT) &&
    ($past(state_reg) != ST_SOFT) && ($past(state_reg) != ST_DUMMY)) |->
    ($past(state_reg) == ST_SAMPLE))
    else $error("soft-start without new sample");
  pg_run_a: assert property (pg_reg |->
    $past(state_reg == ST_RUN) && !$past(pins_s.pg_bad))
    else $error("power good outside regulation");

endmodule : bfr_sequencer

// ---- tb/bfr_power_stage.sv ----
// Behavioural half-bridge, load and sense comparators for the sequencer.
// Assumes gate outputs come from registers on the bench clock.
`timescale 1ns/100ps
module bfr_power_stage
#(
  parameter int P_SENSE_MV = 40
)(
  input  wire logic       i_ls_gate,
  input  wire logic       i_ls_oe,
  input  wire logic [9:0] i_setpt_mv,
  input  wire logic       i_short,
  input  wire logic       i_low_out,
  output logic            o_oc_trip,
  output logic            o_uv_trip,
  output logic            o_pg_bad,
  output logic            o_sp_cmp
);
  // A short only shows as current while the low side conducts
  assign o_oc_trip = i_short & i_ls_gate & i_ls_oe;
  assign o_uv_trip = i_low_out;
  assign o_pg_bad  = i_low_out | i_short;
  // Sense node develops only while the low-side pin is released
  assign o_sp_cmp  = ~i_ls_oe & (i_setpt_mv >= P_SENSE_MV);
endmodule : bfr_power_stage

// ---- tb/tb_top.sv ----
// Self-checking bench of the buck fault sequencer with shortened counts.
// Assumes a power-stage model and AXI4-Lite tasks driven from here.
`timescale 1ns/100ps
module tb_top;
  import bfr_pkg::*;
  localparam int TOUT = 256;
  localparam int SNS  = 40;
  logic        clk;
  logic        nrst;
  logic        en;
  logic        short;
  logic        low;
  logic        pwm;
  logic        oc;
  logic        uv;
  logic        pg_bad;
  logic        spc;
  bfr_pins_t   pins;
  logic        hs;
  logic        ls;
  logic        ls_oe;
  logic [5:0]  refc;
  logic [9:0]  spt;
  logic        pg;
  logic        irq;
  logic [7:0]  awaddr;
  logic [7:0]  araddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] rdat;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [1:0]  rrsp;
  logic [1:0]  brsp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          error_cnt;
  int          checks;
  int          cyc;
  int          hlen;
  int          t0;
  int          sd;
  logic [31:0] m;
  assign pins = {en, oc, uv, pg_bad, spc};
  bfr_sequencer #(.P_TOUT_CYC(TOUT), .P_RAMP_CYC(128), .P_SAMPLE_CYC(64),
    .P_SP_STEP(1)) i_bfr_sequencer (.I_CLK(clk), .I_NRST(nrst),
    .I_CE(1'b1), .I_PINS(pins), .I_PWM_HS(pwm), .O_HS_GATE(hs),
    .O_LS_GATE(ls), .O_LS_GATE_OE(ls_oe), .O_REF_CODE(refc),
    .O_SETPT_MV(spt), .O_POWER_GOOD_FLAG(pg), .O_IRQ(irq),
    .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid),
    .O_AXI_AWREADY(awready), .I_AXI_WDATA(wdata), .I_AXI_WSTRB(4'hF),
    .I_AXI_WVALID(wvalid), .O_AXI_WREADY(wready), .O_AXI_BRESP(bresp),
    .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready), .I_AXI_ARADDR(araddr),
    .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready),
    .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid),
    .I_AXI_RREADY(rready));
  bfr_power_stage #(.P_SENSE_MV(SNS)) i_bfr_power_stage (.i_ls_gate(ls),
    .i_ls_oe(ls_oe), .i_setpt_mv(spt), .i_short(short), .i_low_out(low),
    .o_oc_trip(oc), .o_uv_trip(uv), .o_pg_bad(pg_bad), .o_sp_cmp(spc));
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // Random high-side width, leaving a low-side phase past the blanking
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc % 32 == 0)
      hlen <= $urandom_range(16, 1);
    pwm <= (cyc % 32) < hlen;
  end
  ////////////////////////////////////////////////////////////////////////
  // Two dummy time-outs precede every real soft-start of a retry
  function automatic int retry_hold(input int tout);
    return 2 * tout;
  endfunction : retry_hold
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
  begin
    checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", n, e, s);
    end
  end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
  begin
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    tb = 0;
    while (!tb)
    begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      brsp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      if (tb) bready <= 0;
    end
    @(posedge clk);
  end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
  begin
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    tr = 0;
    while (!tr)
    begin
      @(negedge clk);
      ta = arvalid & arready;
      tr = rvalid;
      rdat = rdata;
      rrsp = rresp;
      @(posedge clk);
      if (ta) arvalid <= 0;
      if (tr) rready <= 0;
    end
    @(posedge clk);
  end
  endtask : rd
  task automatic wst(input logic [2:0] s);
    int n;
  begin
    n = 0;
    rd(ADDR_STATUS);
    while (rdat[2:0] !== s && n < 400)
    begin
      rd(ADDR_STATUS);
      n++;
    end
    chk("state", rdat[2:0], s);
  end
  endtask : wst
  task automatic tally_and_finish;
  begin
    $display("mismatches %0d comparisons %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    tally_and_finish;
  end
  initial
  begin
    sd = $urandom(42886);
    {nrst, en, short, low, awvalid, wvalid, bready} = 7'h20;
    {arvalid, rready, awaddr, araddr, wdata, cyc, hlen} = 0;
    repeat (8) @(posedge clk);
    nrst <= 1;
    wst(1);
    chk("ls_oe", ls_oe, 0);
    chk("gates", {hs, ls}, 0);
    wst(3);
    chk("ref", refc, 63);
    chk("pg_run", pg, 1);
    chk("setpt", spt >= SNS && spt <= SNS + 4, 1);
    rd(ADDR_IRQ_STAT);
    chk("ss_ok", rdat[IRQ_SS_OK], 1);
    rd(ADDR_IRQ_STAT);
    chk("rd_clr", rdat[IRQ_SS_OK], 0);
    rd(8'h20);
    chk("resp", rrsp, RESP_SLVERR);
    chk("rdata", rdat, 0);
    m = $urandom;
    wr(ADDR_IRQ_MASK, m);
    chk("bresp", brsp, RESP_OK);
    wr(8'h20, m);
    chk("bresp_err", brsp, RESP_SLVERR);
    rd(ADDR_IRQ_MASK);
    chk("mask", rdat[3:0], m[3:0]);
    wr(ADDR_IRQ_MASK, 32'h1);
    chk("irq_idle", irq, 0);
    short <= 1;
    wst(4);
    t0 = cyc;
    chk("trip_gates", {hs, ls}, 0);
    chk("power_good_flag", pg, 0);
    chk("irq", irq, 1);
    wst(2);
    t0 = cyc - t0 - retry_hold(TOUT);
    chk("dummy_len", t0 inside {[-8:8]}, 1);
    wst(4);
    rd(ADDR_STATUS);
    chk("oc_lock", rdat[STS_OC_LOCK], 1);
    short <= 0;
    wst(2);
    low <= 1;
    repeat (20) @(posedge clk);
    rd(ADDR_STATUS);
    chk("uv_in_ramp", rdat[2:0], 2);
    low <= 0;
    wst(3);
    low <= 1;
    wst(5);
    chk("uv_gates", {hs, ls}, 0);
    en <= 0;
    repeat (10) @(posedge clk);
    en <= 1;
    repeat (10) @(posedge clk);
    rd(ADDR_STATUS);
    chk("uv_held", rdat[2:0], 5);
    nrst <= 0;
    low <= 0;
    @(posedge clk);
    nrst <= 1;
    wst(1);
    wr(ADDR_CTRL, 0);
    wst(0);
    wr(ADDR_CTRL, 1);
    wst(1);
    chk("ls_oe2", ls_oe, 0);
    tally_and_finish;
  end
endmodule : tb_top
